// [hdl/gsc_pkg.sv]
/*
 * Shared constants for the rate sensor status and configuration register bank:
 * register addresses, field positions, reset values, power modes and decode tables.
 * Assumes an 8-bit register address space reached by a simple register port.
 */
`default_nettype none

package gsc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register addresses
    localparam logic [7:0] ADDR_MOTION_STAT = 8'h09;
    localparam logic [7:0] ADDR_INT_STAT_A  = 8'h0a;
    localparam logic [7:0] ADDR_ANY_DETAIL  = 8'h0b;
    localparam logic [7:0] ADDR_HIGH_DETAIL = 8'h0c;
    localparam logic [7:0] ADDR_FIFO_STAT   = 8'h0e;
    localparam logic [7:0] ADDR_RANGE       = 8'h0f;
    localparam logic [7:0] ADDR_BW          = 8'h10;
    localparam logic [7:0] ADDR_PWR         = 8'h11;
    localparam logic [7:0] ADDR_FIFO_CFG    = 8'h3e;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int STAT_DATA_BIT   = 7;
    localparam int STAT_AUTO_BIT   = 6;
    localparam int STAT_FAST_BIT   = 5;
    localparam int STAT_FIFO_BIT   = 4;
    localparam int MOT_ANY_BIT     = 2;
    localparam int MOT_HIGH_BIT    = 1;
    localparam int FIFO_OVR_BIT    = 7;
    localparam int BW_FIXED_BIT    = 7;
    localparam int BW_RSVD_CODE    = 3;
    localparam int PWR_SUSP_BIT    = 7;
    localparam int PWR_DEEP_BIT    = 5;
    localparam int PWR_SLEEP_LSB   = 1;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and limits
    localparam logic [2:0] RANGE_RST     = 3'h0;
    localparam logic [2:0] RANGE_MAX     = 3'h4;
    localparam logic [3:0] BW_RST        = 4'h0;
    localparam logic [2:0] SLEEP_RST     = 3'h0;
    localparam int         FIFO_DEPTH_DEF = 100;

    typedef enum logic [1:0] {GSC_NORMAL, GSC_SUSPEND, GSC_DEEP} gsc_pmode_e;

    ////////////////////////////////////////////////////////////////////////////
    // Decode tables, indexed by field code
    localparam logic [11:0] FS_DPS [5] = '{12'h7d0, 12'h3e8, 12'h1f4, 12'h0fa, 12'h07d};
    localparam logic [10:0] ODR_HZ [8] = '{11'h7d0, 11'h7d0, 11'h3e8, 11'h190,
                                           11'h0c8, 11'h064, 11'h0c8, 11'h064};
    localparam logic [9:0]  CUT_HZ [8] = '{10'h20b, 10'h0e6, 10'h074, 10'h02f,
                                           10'h017, 10'h00c, 10'h040, 10'h020};
    localparam logic [4:0]  SLEEP_MS [8] = '{5'h02, 5'h04, 5'h05, 5'h08,
                                             5'h0a, 5'h0f, 5'h12, 5'h14};

endpackage

`default_nettype wire

// [hdl/gsc_axis_event.sv]
/*
 * Sticky event flag with triggering-axis and sign capture, one per motion event kind.
 * Assumes evt is a one-cycle pulse on core_clk; clr is a one-cycle read strobe.
 */
`timescale 1ns/1ps
`default_nettype none

module gsc_axis_event
    import gsc_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    // Event source
    input  wire logic       evt,
    input  wire logic       evt_sign,
    input  wire logic [2:0] evt_axis,
    input  wire logic       clr,
    // Status
    output logic            flag_q,
    output logic [3:0]      detail_q
);

    logic       flag_d;
    logic [3:0] detail_d;

    // Set wins so an event landing on the clearing read is kept
    assign flag_d   = evt | (flag_q & ~clr);
    assign detail_d = evt ? {evt_sign, evt_axis} : detail_q;

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            flag_q   <= 1'b0;
            detail_q <= 4'h0;
        end
        else
        begin
            flag_q   <= flag_d;
            detail_q <= detail_d;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    detail_capture_a: assert property (evt |=> detail_q == {$past(evt_sign), $past(evt_axis)}) // R03
        else $error("detail not captured on event");
    flag_kept_a: assert property (evt ##1 !clr |=> flag_q) // R17
        else $error("event flag lost");

endmodule // gsc_axis_event

`default_nettype wire

// [hdl/gsc_regs.sv]
/*
 * Rate sensor status and configuration register bank: event status, motion detail,
 * FIFO fill and overrun, range, output rate and filter, power mode and sleep time.
 * Assumes a host register port on core_clk (one-cycle rd/wr strobes) and event
 * pulses from sensor logic on the same clock.
 */
//  Function
//  R01: Status register A shows new-data in bit 7, FIFO in bit 4, rest zero.
//  R02: Status register A shows auto offset in bit 6, fast offset in bit 5.
//  R03: Any-motion detail bit 3 holds motion sign, one is positive.
//  R04: Any-motion detail bits 2..0 flag z, y, x triggering axis.
//  R05: High-rate detail bit 3 holds rate sign, one is positive.
//  R06: High-rate detail bits 2..0 flag z, y, x triggering axis.
//  R07: FIFO overrun flag sets on overrun, clears only on FIFO config write.
//  R08: FIFO status bits 6..0 give frame count, zero when empty.
//  R09: Frame count returns to zero when drained or on FIFO config write; a frame pushed in the write cycle leaves it at one.
//  R10: Range codes 0..4 select 2000, 1000, 500, 250, 125 dps; others reserved.
//  R11: Bandwidth codes 7..4 select 100/32, 200/64, 100/12, 200/23 Hz.
//  R12: Bandwidth codes 3..0 select 400/47, 1000/116, 2000/230, 2000 unfiltered.
//  R13: Suspend and deep-suspend bits select NORMAL, SUSPEND, DEEP_SUSPEND; both illegal.
//  R14: Host requests only permitted power-mode transitions.
//  R15: Host rewrites non-default settings after leaving deep suspend.
//  R16: Sleep duration codes 0..7 map to 2,4,5,8,10,15,18,20 ms.
//  R17: Any-motion and high-rate flags appear in the motion status register.
//  R18: Reserved bits and reserved codes written are ignored; host writes zero.
//  R19: Configuration resets to zero, bandwidth bit 7 reads as one.
`timescale 1ns/1ps
`default_nettype none

module gsc_regs
    import gsc_pkg::*;
#(
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
)
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [7:0]       reg_rdata_q,
    // Event pulses
    input  wire logic        data_evt,
    input  wire logic        auto_offset_evt,
    input  wire logic        fast_offset_evt,
    input  wire logic        fifo_evt,
    input  wire logic        any_evt,
    input  wire logic        any_sign,
    input  wire logic [2:0]  any_axis,
    input  wire logic        high_evt,
    input  wire logic        high_sign,
    input  wire logic [2:0]  high_axis,
    // FIFO frame movement
    input  wire logic        fifo_push,
    input  wire logic        fifo_pop,
    output logic [6:0]       fifo_level_q,
    output logic             fifo_overrun_q,
    // Configuration
    output logic [2:0]       range_code_q,
    output logic [11:0]      full_scale_dps_q,
    output logic [3:0]       filter_cutoff_code_q,
    output logic [10:0]      odr_hz_q,
    output logic [9:0]       cutoff_hz_q,
    output gsc_pmode_e       power_mode_q,
    output logic [2:0]       sleep_dur_code_q,
    output logic [4:0]       sleep_ms_q
);

    localparam logic [6:0] DEPTH_C = 7'(FIFO_DEPTH);

    ////////////////////////////////////////////////////////////////////////////
    // Address decode
    wire wr_range    = reg_wr && reg_addr == ADDR_RANGE;
    wire wr_bw       = reg_wr && reg_addr == ADDR_BW;
    wire wr_pwr      = reg_wr && reg_addr == ADDR_PWR;
    wire wr_fifo_cfg = reg_wr && reg_addr == ADDR_FIFO_CFG;
    wire rd_stat_a   = reg_rd && reg_addr == ADDR_INT_STAT_A;
    wire rd_motion   = reg_rd && reg_addr == ADDR_MOTION_STAT;

    ////////////////////////////////////////////////////////////////////////////
    // Event status, register A
    logic [3:0] stat_a_q;
    logic [3:0] stat_a_d;
    wire  [3:0] stat_a_set = {data_evt, auto_offset_evt, fast_offset_evt, fifo_evt};

    // Reading clears; a same-cycle event still sets
    assign stat_a_d = stat_a_set | (stat_a_q & ~{4{rd_stat_a}}); // R01 R02

    ////////////////////////////////////////////////////////////////////////////
    // Motion events with axis and sign
    logic       any_flag;
    logic       high_flag;
    logic [3:0] any_detail;
    logic [3:0] high_detail;

    gsc_axis_event u_any_evt (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .evt      (any_evt),
        .evt_sign (any_sign),
        .evt_axis (any_axis),
        .clr      (rd_motion),
        .flag_q   (any_flag),
        .detail_q (any_detail)
    ); // R03 R04

    gsc_axis_event u_high_evt (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .evt      (high_evt),
        .evt_sign (high_sign),
        .evt_axis (high_axis),
        .clr      (rd_motion),
        .flag_q   (high_flag),
        .detail_q (high_detail)
    ); // R05 R06

    ////////////////////////////////////////////////////////////////////////////
    // FIFO fill level and overrun
    // A pop at full frees the slot that the push refills, so the level holds
    wire do_push = fifo_push && (fifo_level_q != DEPTH_C || fifo_pop);
    wire do_pop  = fifo_pop && (fifo_level_q != 7'h00);
    wire ovr_evt = fifo_push && (fifo_level_q == DEPTH_C) && !fifo_pop;
    logic [6:0] fifo_level_d;
    logic       fifo_overrun_d;

    // Config write empties the count; a frame arriving that cycle is still counted
    assign fifo_level_d = wr_fifo_cfg ? {6'h00, fifo_push}                    // R09
                        : (do_push && !do_pop) ? fifo_level_q + 7'h01
                        : (do_pop && !do_push) ? fifo_level_q - 7'h01         // R08
                        : fifo_level_q;
    assign fifo_overrun_d = ovr_evt | (fifo_overrun_q & ~wr_fifo_cfg);        // R07

    ////////////////////////////////////////////////////////////////////////////
    // Range, bandwidth and power configuration
    logic       susp_q;
    logic       deep_q;
    logic [2:0] range_d;
    logic [3:0] bw_d;
    logic       susp_d;
    logic       deep_d;
    logic [2:0] sleep_d;
    gsc_pmode_e mode_d;

    wire range_ok   = reg_wdata[2:0] <= RANGE_MAX;                            // R18
    wire bw_ok      = !reg_wdata[BW_RSVD_CODE];                               // R18
    wire pwr_legal  = !(reg_wdata[PWR_SUSP_BIT] && reg_wdata[PWR_DEEP_BIT]);  // R13
    wire deep_entry = wr_pwr && pwr_legal && reg_wdata[PWR_DEEP_BIT] && !deep_q;

    // Deep suspend drops the settings it does not retain
    assign range_d = deep_entry ? RANGE_RST
                   : (wr_range && range_ok) ? reg_wdata[2:0] : range_code_q;  // R10
    assign bw_d    = deep_entry ? BW_RST
                   : (wr_bw && bw_ok) ? reg_wdata[3:0] : filter_cutoff_code_q; // R11 R12
    assign susp_d  = (wr_pwr && pwr_legal) ? reg_wdata[PWR_SUSP_BIT] : susp_q;
    assign deep_d  = (wr_pwr && pwr_legal) ? reg_wdata[PWR_DEEP_BIT] : deep_q;
    assign sleep_d = wr_pwr ? reg_wdata[PWR_SLEEP_LSB +: 3] : sleep_dur_code_q;

    always_comb
    begin
        case ({susp_d, deep_d})
            2'b00:   mode_d = GSC_NORMAL;                                     // R13
            2'b01:   mode_d = GSC_DEEP;
            2'b10:   mode_d = GSC_SUSPEND;
            default: mode_d = GSC_NORMAL;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux; reserved bits read zero, bandwidth bit 7 reads one
    logic [7:0] rd_mux;

    always_comb
    begin
        case (reg_addr)
            ADDR_MOTION_STAT: rd_mux = {5'h00, any_flag, high_flag, 1'b0};    // R17
            ADDR_INT_STAT_A:  rd_mux = {stat_a_q, 4'h0};                       // R01 R02
            ADDR_ANY_DETAIL:  rd_mux = {4'h0, any_detail};                    // R03 R04
            ADDR_HIGH_DETAIL: rd_mux = {4'h0, high_detail};                   // R05 R06
            ADDR_FIFO_STAT:   rd_mux = {fifo_overrun_q, fifo_level_q};        // R07 R08
            ADDR_RANGE:       rd_mux = {5'h00, range_code_q};
            ADDR_BW:          rd_mux = {1'b1, 3'h0, filter_cutoff_code_q};    // R19
            ADDR_PWR:         rd_mux = {susp_q, 1'b0, deep_q, 1'b0, sleep_dur_code_q, 1'b0};
            default:          rd_mux = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // State
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stat_a_q       <= 4'h0;
            fifo_level_q   <= 7'h00;
            fifo_overrun_q <= 1'b0;
            reg_rdata_q    <= 8'h00;
        end
        else
        begin
            stat_a_q       <= stat_a_d;
            fifo_level_q   <= fifo_level_d;
            fifo_overrun_q <= fifo_overrun_d;
            reg_rdata_q    <= reg_rd ? rd_mux : reg_rdata_q;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            range_code_q         <= RANGE_RST;                                // R19
            filter_cutoff_code_q <= BW_RST;
            susp_q               <= 1'b0;
            deep_q               <= 1'b0;
            sleep_dur_code_q     <= SLEEP_RST;
            power_mode_q         <= GSC_NORMAL;
            full_scale_dps_q     <= FS_DPS[0];
            odr_hz_q             <= ODR_HZ[0];
            cutoff_hz_q          <= CUT_HZ[0];
            sleep_ms_q           <= SLEEP_MS[0];
        end
        else
        begin
            range_code_q         <= range_d;
            filter_cutoff_code_q <= bw_d;
            susp_q               <= susp_d;
            deep_q               <= deep_d;
            sleep_dur_code_q     <= sleep_d;
            power_mode_q         <= mode_d;
            full_scale_dps_q     <= FS_DPS[range_d];                          // R10
            odr_hz_q             <= ODR_HZ[bw_d[2:0]];                        // R11 R12
            cutoff_hz_q          <= CUT_HZ[bw_d[2:0]];
            sleep_ms_q           <= SLEEP_MS[sleep_d];                        // R16
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    stat_set_wins_a: assert property (data_evt |=> stat_a_q[3]) // R01
        else $error("new-data status lost");
    offset_flags_a: assert property (auto_offset_evt && fast_offset_evt |=> stat_a_q[2:1] == 2'b11) // R02
        else $error("offset status not set");
    overrun_hold_a: assert property (fifo_overrun_q && !wr_fifo_cfg |=> fifo_overrun_q) // R07
        else $error("overrun cleared without config write");
    level_bound_a: assert property (fifo_level_q <= DEPTH_C) // R08
        else $error("fifo level above depth");
    cfg_clear_a: assert property (wr_fifo_cfg && !fifo_push |=> fifo_level_q == 7'h00 && !fifo_overrun_q) // R09
        else $error("config write did not clear fifo status");
    range_rsvd_a: assert property (wr_range && reg_wdata[2:0] > RANGE_MAX && !deep_entry
                                   |=> $stable(range_code_q)) // R18
        else $error("reserved range code taken");
    range_scale_a: assert property (range_code_q == 3'h4 |-> full_scale_dps_q == 12'h07d) // R10
        else $error("full scale mismatch");
    bw_rsvd_a: assert property (wr_bw && reg_wdata[3] && !deep_entry |=> $stable(filter_cutoff_code_q)) // R18
        else $error("reserved bandwidth code taken");
    bw_rate_a: assert property (filter_cutoff_code_q == 4'h3 |-> odr_hz_q == 11'h190 && cutoff_hz_q == 10'h02f) // R12
        else $error("rate or cutoff mismatch");
    mode_legal_a: assert property (wr_pwr && reg_wdata[7] && reg_wdata[5] |=> $stable(power_mode_q)) // R13
        else $error("illegal power mode accepted");
    sleep_map_a: assert property (wr_pwr && reg_wdata[3:1] == 3'h6 |=> sleep_ms_q == 5'h12) // R16
        else $error("sleep duration mismatch");
    read_latency_a: assert property (reg_rd && reg_addr == ADDR_BW |=> reg_rdata_q[7]) // R19
        else $error("bandwidth bit 7 not one");
    stat_clear_a: assert property (rd_stat_a && stat_a_set == 4'h0 |=> stat_a_q == 4'h0) // R01
        else $error("status not cleared by read");
    full_swap_a: assert property (fifo_push && fifo_pop && !wr_fifo_cfg // R08
                                  && fifo_level_q == DEPTH_C |=> fifo_level_q == DEPTH_C)
        else $error("push and pop at full changed level");
    empty_pop_a: assert property (fifo_pop && !fifo_push && !wr_fifo_cfg // R09
                                  && fifo_level_q == 7'h00 |=> fifo_level_q == 7'h00)
        else $error("pop on empty fifo moved level");
    ovr_read_a: assert property (reg_rd && reg_addr == ADDR_FIFO_STAT // R07
                                 |=> reg_rdata_q[7] == $past(fifo_overrun_q))
        else $error("overrun flag not read back");
    deep_lost_a: assert property (deep_entry // R15
                                  |=> range_code_q == RANGE_RST && filter_cutoff_code_q == BW_RST)
        else $error("settings kept over deep suspend");

endmodule // gsc_regs

`default_nettype wire

// [dv/gsc_host.sv]
/*
 * Host processor model: drives the register port with one-cycle read and write strobes.
 * Assumes core_clk from the bench; its tasks are called by hierarchical name.
 */
`timescale 1ns/1ps
`default_nettype none

module gsc_host
(
    // Clock
    input  wire logic       core_clk,
    // Register port
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata_q
);
    initial
    begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Requests launch at the falling edge so the rising edge sees settled values
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge core_clk);
        reg_wr    = 1'b0;
        reg_wdata = ~d;  // Released data must not look like the last write
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge core_clk);
        reg_rd   = 1'b0;
        d        = reg_rdata_q;
    endtask
endmodule // gsc_host

`default_nettype wire

// [dv/gsc_regs_test.sv]
/*
 * Self-checking bench for the status and configuration register bank.
 * Assumes the host model in gsc_host.sv; the FIFO depth is shrunk to 4 frames.
 */
`timescale 1ns/1ps
`default_nettype none

module gsc_regs_test
    import gsc_pkg::*;
;
    localparam int DEPTH = 4;
    logic        core_clk = 1'b0;
    logic        reset_n  = 1'b0;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata_q, d;
    logic        reg_wr, reg_rd;
    logic        data_evt = 0, auto_offset_evt = 0, fast_offset_evt = 0, fifo_evt = 0;
    logic        any_evt = 0, any_sign = 0, high_evt = 0, high_sign = 0;
    logic [2:0]  any_axis = 0, high_axis = 0;
    logic        fifo_push = 0, fifo_pop = 0, fifo_overrun_q;
    logic [6:0]  fifo_level_q;
    logic [2:0]  range_code_q, sleep_dur_code_q;
    logic [11:0] full_scale_dps_q;
    logic [3:0]  filter_cutoff_code_q;
    logic [10:0] odr_hz_q;
    logic [9:0]  cutoff_hz_q;
    logic [4:0]  sleep_ms_q;
    gsc_pmode_e  power_mode_q;
    int          error_cnt = 0;
    int          checked   = 0;
    int          fs[5]   = '{2000, 1000, 500, 250, 125};
    int          odr[8]  = '{2000, 2000, 1000, 400, 200, 100, 200, 100};
    int          cut[8]  = '{523, 230, 116, 47, 23, 12, 64, 32};
    int          slp[8]  = '{2, 4, 5, 8, 10, 15, 18, 20};

    always #25 core_clk = ~core_clk;

    gsc_host host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
                   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));

    gsc_regs #(.FIFO_DEPTH(DEPTH)) dut (
        .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_q(reg_rdata_q), .data_evt(data_evt), .auto_offset_evt(auto_offset_evt),
        .fast_offset_evt(fast_offset_evt), .fifo_evt(fifo_evt), .any_evt(any_evt),
        .any_sign(any_sign), .any_axis(any_axis), .high_evt(high_evt),
        .high_sign(high_sign), .high_axis(high_axis), .fifo_push(fifo_push),
        .fifo_pop(fifo_pop), .fifo_level_q(fifo_level_q), .fifo_overrun_q(fifo_overrun_q),
        .range_code_q(range_code_q), .full_scale_dps_q(full_scale_dps_q),
        .filter_cutoff_code_q(filter_cutoff_code_q), .odr_hz_q(odr_hz_q),
        .cutoff_hz_q(cutoff_hz_q), .power_mode_q(power_mode_q),
        .sleep_dur_code_q(sleep_dur_code_q), .sleep_ms_q(sleep_ms_q));

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    task automatic chk(input string n, input logic [11:0] got, input logic [11:0] exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %s exp %h got %h", n, exp, got);
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, d);
        chk($sformatf("reg %h", a), {4'h0, d}, {4'h0, e});
    endtask

    // One-cycle pulse on any mix of event and FIFO inputs
    task automatic pulse(input logic [15:0] v);
        @(negedge core_clk);
        {data_evt, auto_offset_evt, fast_offset_evt, fifo_evt, any_evt, any_sign, any_axis,
         high_evt, high_sign, high_axis, fifo_push, fifo_pop} = v;
        @(negedge core_clk);
        {data_evt, auto_offset_evt, fast_offset_evt, fifo_evt, any_evt, any_sign, any_axis,
         high_evt, high_sign, high_axis, fifo_push, fifo_pop} = 16'h0000;
    endtask

    task automatic complete_run;
        if (error_cnt == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        #(50 * 20000);
        error_cnt++;
        complete_run();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (10) @(negedge core_clk);
        reset_n = 1'b1;
        rdc(ADDR_RANGE, 8'h00);
        rdc(ADDR_BW, 8'h80);
        rdc(ADDR_PWR, 8'h00);
        chk("cutoff", 12'(cutoff_hz_q), 12'h20b);
        rdc(8'h0d, 8'h00);
        for (int i = 0; i < 5; i++)
        begin
            host.wr(ADDR_RANGE, 8'(i));
            chk("fs", full_scale_dps_q, 12'(fs[i]));
            chk("range", 12'(range_code_q), 12'(i));
        end
        host.wr(ADDR_RANGE, 8'h05);
        chk("fs rsvd", full_scale_dps_q, 12'h07d);
        rdc(ADDR_RANGE, 8'h04);
        for (int i = 0; i < 8; i++)
        begin
            host.wr(ADDR_BW, 8'(i));
            chk("odr", 12'(odr_hz_q), 12'(odr[i]));
            chk("cut", 12'(cutoff_hz_q), 12'(cut[i]));
        end
        host.wr(ADDR_BW, 8'h08);
        chk("bw code", 12'(filter_cutoff_code_q), 12'h007);
        rdc(ADDR_BW, 8'h87);
        for (int i = 0; i < 8; i++)
        begin
            host.wr(ADDR_PWR, {4'h0, 3'(i), 1'b0});
            chk("sleep", 12'(sleep_ms_q), 12'(slp[i]));
            chk("sleep code", 12'(sleep_dur_code_q), 12'(i));
        end
        // Permitted transitions go through NORMAL; one illegal suspend plus deep-suspend request is also made
        host.wr(ADDR_PWR, 8'h80);
        chk("mode susp", 12'(power_mode_q), 12'(GSC_SUSPEND));
        host.wr(ADDR_PWR, 8'h00);
        host.wr(ADDR_PWR, 8'ha2);
        chk("mode ill", 12'(power_mode_q), 12'(GSC_NORMAL));
        chk("sleep ill", 12'(sleep_ms_q), 12'h004);
        host.wr(ADDR_RANGE, 8'h03);
        host.wr(ADDR_PWR, 8'h20);
        chk("mode deep", 12'(power_mode_q), 12'(GSC_DEEP));
        chk("fs lost", full_scale_dps_q, 12'h7d0);
        host.wr(ADDR_PWR, 8'h00);
        chk("mode norm", 12'(power_mode_q), 12'(GSC_NORMAL));
        host.wr(ADDR_RANGE, 8'h03);
        chk("fs again", full_scale_dps_q, 12'h0fa);
        pulse(16'hf000);
        host.wr(ADDR_INT_STAT_A, 8'h00);
        rdc(ADDR_INT_STAT_A, 8'hf0);
        rdc(ADDR_INT_STAT_A, 8'h00);
        pulse(16'h0e00);
        rdc(ADDR_MOTION_STAT, 8'h04);
        rdc(ADDR_ANY_DETAIL, 8'h0c);
        pulse(16'h0044);
        rdc(ADDR_MOTION_STAT, 8'h02);
        rdc(ADDR_HIGH_DETAIL, 8'h01);
        rdc(ADDR_ANY_DETAIL, 8'h0c);
        rdc(ADDR_FIFO_STAT, 8'h00);
        for (int i = 0; i <= DEPTH; i++)
            pulse(16'h0002);
        chk("level", 12'(fifo_level_q), 12'(DEPTH));
        rdc(ADDR_FIFO_STAT, 8'h80 | 8'(DEPTH));
        chk("ovr", 12'(fifo_overrun_q), 12'h001);
        pulse(16'h0003);
        chk("level swap", 12'(fifo_level_q), 12'(DEPTH));
        for (int i = 0; i <= DEPTH; i++)
            pulse(16'h0001);
        rdc(ADDR_FIFO_STAT, 8'h80);
        host.wr(ADDR_FIFO_CFG, 8'h00);
        rdc(ADDR_FIFO_STAT, 8'h00);
        pulse(16'h0002);
        pulse(16'h0002);
        host.wr(ADDR_FIFO_CFG, 8'h00);
        chk("level clr", 12'(fifo_level_q), 12'h000);
        // Mid-run reset must bring the defaults back at once
        @(negedge core_clk);
        reset_n = 1'b0;
        @(negedge core_clk);
        chk("fs in rst", full_scale_dps_q, 12'h7d0);
        reset_n = 1'b1;
        rdc(ADDR_RANGE, 8'h00);
        rdc(ADDR_BW, 8'h80);
        complete_run();
    end
endmodule // gsc_regs_test

`default_nettype wire
